// File: hw/iofp_pkg.sv
// iofp_pkg: register map, field positions, timing and carrier types
// for the i/o strobe cycle engine and the two flag pins.
// assumes a single 125 MHz clock domain; nothing else.
package iofp_pkg;

  // ********************************************************************
  // register map (word-aligned byte addresses)
  // ********************************************************************
  localparam logic [3:0] ADDR_FLAG_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IO_ADDR = 4'h4;
  localparam logic [3:0] ADDR_IO_WDATA = 4'h8;
  localparam logic [3:0] ADDR_IO_CMD = 4'hC;
  localparam logic [3:0] ADDR_IO_RDATA = 4'h8;
  localparam logic [3:0] ADDR_IO_STAT = 4'h4;

  // ********************************************************************
  // flag control fields and command bits
  // ********************************************************************
  localparam int DIR0_BIT = 1;
  localparam int OUT0_BIT = 2;
  localparam int IN0_BIT = 3;
  localparam int DIR1_BIT = 5;
  localparam int OUT1_BIT = 6;
  localparam int IN1_BIT = 7;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_RD_BIT = 1;
  localparam int CMD_LOCK_BIT = 2;
  localparam logic [31:0] FLAG_CTRL_RESET = 32'h0000_0000;

  // ********************************************************************
  // phase clock timing: one phase cycle = PHASE_DIV system clocks
  // ********************************************************************
  localparam int PHASE_NS = 48;
  localparam int SYS_NS = 8;
  localparam int PHASE_DIV = PHASE_NS / SYS_NS;

  // ********************************************************************
  // carrier types
  // ********************************************************************
  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] wdata;
    logic read;
    logic locked;
  } iofp_req_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] data;
    logic data_oe;
    logic rd_wr;
    logic strobe_n;
  } iofp_bus_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b010
  } iofp_state_type;

endpackage

// File: hw/iofp_phase_gen.sv
// iofp_phase_gen: builds the two-phase timing from sys_clk and gives
// one-cycle pulses on the rise and fall of each phase.
// assumes sys_clk and resetn from the owning block.
`timescale 1ns/1ps
module iofp_phase_gen #(
  parameter int DIV = iofp_pkg::PHASE_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // phase event pulses
  output logic p1_rise,
  output logic p1_fall,
  output logic p3_rise,
  output logic p3_fall
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  wire logic wrap;
  // phase one high in the first half, phase three in the second
  assign wrap = (cnt_q == 4'(DIV - 1));
  assign cnt_d = wrap ? 4'h0 : cnt_q + 4'h1;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
      p1_rise <= 1'b0;
      p1_fall <= 1'b0;
      p3_rise <= 1'b0;
      p3_fall <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      p1_rise <= wrap;
      p1_fall <= (cnt_q == 4'(DIV / 2 - 1));
      p3_rise <= (cnt_q == 4'(DIV / 2 - 1));
      p3_fall <= wrap;
    end
  end
endmodule // iofp_phase_gen

// File: hw/iofp_sync2.sv
// iofp_sync2: two-stage synchroniser for pin inputs.
// assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module iofp_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // iofp_sync2

// File: hw/iofp_top.sv
// iofp_top: i/o strobe bus cycle engine and two flag pins, with an
// avalon-mm register slave for software.
// assumes a 125 MHz sys_clk, async active-low reset, and an external
// tristate resolver for the data bus and flag pins.
//
// Summary of operation
// - io strobe falls then rises, each on a phase-one rising edge.
// - address is presented from a phase-one falling edge.
// - read cycles drive read/write high from a phase-one falling edge.
// - read data captured at phase-one rise ending the cycle.
// - write cycles drive read/write low from a phase-one falling edge.
// - write data driven after phase-one rise, through next fall.
// - write data held until the phase-one fall after the cycle.
// - interlocked load drives flag pin zero low from phase-three rise.
// - interlocked load samples flag pin one on phase-one fall.
// - output flag pin follows its output bit from phase-three rise.
// - output-value bits are bit 2 and bit 6.
// - direction bits are bit 1 and bit 5.
// - input-value bits are bit 3 and bit 7, sampled pin levels.
// - output-to-input releases drive at phase-three rise, then samples.
// - input-to-output starts driving at a phase-three rise.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module iofp_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // i/o strobe bus
  output logic io_space_strobe_n,
  output logic expansion_read_write,
  output logic [23:0] io_addr,
  output logic [31:0] io_data_out,
  output logic io_data_oe,
  input wire logic [31:0] io_data_in,
  input wire logic io_ready_n,
  // flag pins
  input wire logic [1:0] flag_pin_n_in,
  output logic [1:0] flag_pin_n_out,
  output logic [1:0] flag_pin_n_oe
);

  // ********************************************************************
  // phase timing and pin synchronisers
  // ********************************************************************
  logic p1_rise, p1_fall, p3_rise, p3_fall;
  logic [1:0] flag_sync;
  logic ready_n_sync;
  logic [31:0] data_sync;

  iofp_phase_gen u_phase (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .p1_rise(p1_rise),
    .p1_fall(p1_fall),
    .p3_rise(p3_rise),
    .p3_fall(p3_fall)
  );

  iofp_sync2 #(.W(35)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din({flag_pin_n_in, io_ready_n, io_data_in}),
    .dout({flag_sync, ready_n_sync, data_sync})
  );

  // ********************************************************************
  // registers
  // ********************************************************************
  iofp_pkg::iofp_state_type state_q;
  iofp_pkg::iofp_req_type req_q;
  iofp_pkg::iofp_bus_type bus_q;
  logic [7:0] fctl_q;
  logic [31:0] rdata_q;
  logic busy_q, done_q, lock_q, flag1_seen_q;
  logic [1:0] out_pend_q, dir_pend_q, pin_val_q, pin_oe_q;

  // ********************************************************************
  // bus decode
  // ********************************************************************
  wire logic wr_fctl = avs_write && avs_waitrequest == 1'b0
    && avs_address == iofp_pkg::ADDR_FLAG_CTRL;
  wire logic wr_addr = avs_write && !avs_waitrequest
    && avs_address == iofp_pkg::ADDR_IO_ADDR;
  wire logic wr_wdat = avs_write && !avs_waitrequest
    && avs_address == iofp_pkg::ADDR_IO_WDATA;
  wire logic wr_cmd = avs_write && !avs_waitrequest
    && avs_address == iofp_pkg::ADDR_IO_CMD
    && avs_writedata[iofp_pkg::CMD_GO_BIT] && !busy_q;
  // status clear-on-read acts on the edge that captures the status word
  wire logic rd_stat_cap = avs_read && avs_waitrequest
    && avs_address == iofp_pkg::ADDR_IO_STAT;
  wire logic [31:0] stat_word = {29'h0, flag1_seen_q, done_q, busy_q};
  wire logic [31:0] fctl_word = {24'h0, fctl_q};
  wire logic [31:0] rd_mux =
    (avs_address == iofp_pkg::ADDR_FLAG_CTRL) ? fctl_word :
    (avs_address == iofp_pkg::ADDR_IO_STAT) ? stat_word :
    (avs_address == iofp_pkg::ADDR_IO_RDATA) ? rdata_q :
    (avs_address == iofp_pkg::ADDR_IO_CMD) ? {8'h0, req_q.addr} :
    32'h0000_0000;
  wire logic ready_seen = p1_rise && !ready_n_sync;
  // direction and value of each pin as software asked for it
  wire logic [1:0] dir_sw = {fctl_q[iofp_pkg::DIR1_BIT],
    fctl_q[iofp_pkg::DIR0_BIT]};
  wire logic [1:0] out_sw = {fctl_q[iofp_pkg::OUT1_BIT],
    fctl_q[iofp_pkg::OUT0_BIT]};

  // ********************************************************************
  // avalon slave: one wait cycle per access, then read data registered
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ********************************************************************
  // flag control register: software bits plus sampled input levels
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fctl_q <= iofp_pkg::FLAG_CTRL_RESET[7:0];
      out_pend_q <= 2'h0;
      dir_pend_q <= 2'h0;
    end else begin
      if (wr_fctl) begin
        fctl_q[iofp_pkg::DIR0_BIT] <= avs_writedata[iofp_pkg::DIR0_BIT];
        fctl_q[iofp_pkg::OUT0_BIT] <= avs_writedata[iofp_pkg::OUT0_BIT];
        fctl_q[iofp_pkg::DIR1_BIT] <= avs_writedata[iofp_pkg::DIR1_BIT];
        fctl_q[iofp_pkg::OUT1_BIT] <= avs_writedata[iofp_pkg::OUT1_BIT];
      end
      // inputs sampled at phase-one fall while not driven
      if (p1_fall && !pin_oe_q[0]) begin
        fctl_q[iofp_pkg::IN0_BIT] <= flag_sync[0];
      end
      if (p1_fall && !pin_oe_q[1]) begin
        fctl_q[iofp_pkg::IN1_BIT] <= flag_sync[1];
      end
      out_pend_q <= out_sw;
      dir_pend_q <= dir_sw;
    end
  end

  // ********************************************************************
  // flag pin drivers: all changes launched at phase-three rise
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_val_q <= 2'h0;
      pin_oe_q <= 2'h0;
    end else if (p3_rise) begin
      pin_oe_q <= dir_pend_q;
      pin_val_q <= out_pend_q;
      if (lock_q && req_q.read) begin
        pin_val_q[0] <= 1'b0;
        pin_oe_q[0] <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // i/o strobe cycle: setup at p1 fall, strobe low at p1 rise,
  // wait for ready, strobe high at p1 rise, hold data to p1 fall
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= iofp_pkg::ST_IDLE;
      req_q <= '0;
      bus_q <= '{addr: 24'h0, data: 32'h0, data_oe: 1'b0,
        rd_wr: 1'b1, strobe_n: 1'b1};
      rdata_q <= 32'h0000_0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      lock_q <= 1'b0;
      flag1_seen_q <= 1'b0;
    end else begin
      if (wr_addr) begin
        req_q.addr <= avs_writedata[23:0];
      end
      if (wr_wdat) begin
        req_q.wdata <= avs_writedata;
      end
      // clear only what software has seen; a new completion wins
      if (rd_stat_cap) begin
        done_q <= 1'b0;
      end
      case (state_q)
        iofp_pkg::ST_IDLE: begin
          if (wr_cmd) begin
            req_q.read <= avs_writedata[iofp_pkg::CMD_RD_BIT];
            lock_q <= avs_writedata[iofp_pkg::CMD_LOCK_BIT];
            busy_q <= 1'b1;
            state_q <= iofp_pkg::ST_SETUP;
          end
        end
        iofp_pkg::ST_SETUP: begin
          if (p1_fall) begin
            bus_q.addr <= req_q.addr;
            bus_q.rd_wr <= req_q.read;
            if (lock_q && req_q.read) begin
              flag1_seen_q <= flag_sync[1];
            end
            state_q <= iofp_pkg::ST_STROBE;
          end
        end
        iofp_pkg::ST_STROBE: begin
          if (p1_rise && bus_q.strobe_n) begin
            bus_q.strobe_n <= 1'b0;
            if (!req_q.read) begin
              bus_q.data <= req_q.wdata;
              bus_q.data_oe <= 1'b1;
            end
          end else if (ready_seen && !bus_q.strobe_n) begin
            bus_q.strobe_n <= 1'b1;
            if (req_q.read) begin
              rdata_q <= data_sync;
            end
            state_q <= iofp_pkg::ST_HOLD;
          end
        end
        iofp_pkg::ST_HOLD: begin
          if (p1_fall) begin
            bus_q.data_oe <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            lock_q <= 1'b0;
            state_q <= iofp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= iofp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // pin outputs straight from flops
  // ********************************************************************
  assign io_space_strobe_n = bus_q.strobe_n;
  assign expansion_read_write = bus_q.rd_wr;
  assign io_addr = bus_q.addr;
  assign io_data_out = bus_q.data;
  assign io_data_oe = bus_q.data_oe;
  assign flag_pin_n_out = pin_val_q;
  assign flag_pin_n_oe = pin_oe_q;

  // ********************************************************************
  // assertions
  // ********************************************************************
  sequence s_strobe_fall;
    $fell(bus_q.strobe_n);
  endsequence

  a_strobe_fall_edge: assert property (@(posedge sys_clk) disable iff
    (!resetn) s_strobe_fall |-> $past(p1_rise))
    else $error("strobe fell off a phase-one rise");
  a_strobe_rise_edge: assert property (@(posedge sys_clk) disable iff
    (!resetn) $rose(bus_q.strobe_n) |-> $past(ready_seen))
    else $error("strobe rose without ready at phase-one rise");
  a_addr_launch: assert property (@(posedge sys_clk) disable iff
    (!resetn) $changed(bus_q.addr) |-> $past(p1_fall))
    else $error("address changed off a phase-one fall");
  a_rw_launch: assert property (@(posedge sys_clk) disable iff
    (!resetn) $changed(bus_q.rd_wr) |-> $past(p1_fall))
    else $error("read/write changed off a phase-one fall");
  a_rw_matches_dir: assert property (@(posedge sys_clk) disable iff
    (!resetn) !bus_q.strobe_n |-> bus_q.rd_wr == req_q.read)
    else $error("read/write level wrong during strobe");
  a_wdata_hold: assert property (@(posedge sys_clk) disable iff
    (!resetn) $fell(bus_q.data_oe) |-> $past(p1_fall)
    && $past(state_q) == iofp_pkg::ST_HOLD)
    else $error("write data released early");
  a_wdata_driven: assert property (@(posedge sys_clk) disable iff
    (!resetn) !bus_q.strobe_n && !req_q.read |-> bus_q.data_oe)
    else $error("write data not driven during strobe");
  a_rdata_capture: assert property (@(posedge sys_clk) disable iff
    (!resetn) $rose(bus_q.strobe_n) && req_q.read
    |-> rdata_q == $past(data_sync))
    else $error("read data not captured at cycle end");
  a_flag_launch: assert property (@(posedge sys_clk) disable iff
    (!resetn) $changed(pin_oe_q) || $changed(pin_val_q)
    |-> $past(p3_rise))
    else $error("flag pin changed off a phase-three rise");
  a_lock_flag0: assert property (@(posedge sys_clk) disable iff
    (!resetn) p3_rise && lock_q && req_q.read
    |=> pin_oe_q[0] && !pin_val_q[0])
    else $error("flag pin zero not low during locked load");
  a_in_sample: assert property (@(posedge sys_clk) disable iff
    (!resetn) p1_fall && !pin_oe_q[0]
    |=> fctl_q[iofp_pkg::IN0_BIT] == $past(flag_sync[0]))
    else $error("flag pin zero input not sampled at phase-one fall");

endmodule // iofp_top

// File: verification/iofp_periph_model.sv
// iofp_periph_model: i/o peripheral answering the strobe bus cycle.
// assumes the strobe bus ports of iofp_top and the same sys_clk.
`timescale 1ns/1ps
module iofp_periph_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // strobe bus from the block
  input wire logic strobe_n,
  input wire logic rw,
  input wire logic [23:0] addr,
  input wire logic [31:0] dout,
  input wire logic oe,
  output logic [31:0] din,
  output logic ready_n,
  // test control and observation
  input wire logic [7:0] wait_cyc,
  input wire logic [31:0] rd_val,
  output logic [31:0] seen_data,
  output logic [23:0] seen_addr,
  output logic seen_rw,
  output logic [7:0] low_cnt,
  output logic [7:0] hold_cnt,
  output logic [7:0] cyc_cnt,
  output logic drive_bad
);
  logic prev_q;
  logic after_q;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {prev_q, after_q, seen_rw, drive_bad} <= 4'h8;
      {low_cnt, hold_cnt, cyc_cnt} <= 24'h0;
      {din, seen_data, seen_addr} <= 88'h0;
      ready_n <= 1'b1;
    end else begin
      prev_q <= strobe_n;
      if (!strobe_n) begin
        low_cnt <= prev_q ? 8'h01 : low_cnt + 8'h01;
        if (!rw && !oe)
          drive_bad <= 1'b1;
        if (!prev_q && low_cnt >= wait_cyc) begin
          ready_n <= 1'b0;
          din <= rd_val;
        end
      end else if (!prev_q) begin
        {seen_data, seen_addr, seen_rw} <= {dout, addr, rw};
        cyc_cnt <= cyc_cnt + 8'h01;
        {hold_cnt, after_q} <= 9'h001;
        // released: leave no stale level behind
        ready_n <= 1'b1;
        din <= ~din;
      end else if (after_q) begin
        if (!oe)
          after_q <= 1'b0;
        else
          hold_cnt <= hold_cnt + 8'h01;
        if (oe && dout !== seen_data)
          drive_bad <= 1'b1;
      end
    end
  end
endmodule // iofp_periph_model

// File: verification/tb_io_strobe_and_flag_pins.sv
// tb_io_strobe_and_flag_pins: self-checking bench for iofp_top.
// assumes iofp_pkg, iofp_top and iofp_periph_model are compiled first.
`timescale 1ns/1ps
module tb_io_strobe_and_flag_pins;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, io_data_out, io_data_in;
  logic io_space_strobe_n, expansion_read_write, io_data_oe, io_ready_n;
  logic [23:0] io_addr, seen_addr;
  logic [1:0] flag_pin_n_in, flag_pin_n_out, flag_pin_n_oe, peer_lvl;
  logic [7:0] wait_cyc, low_cnt, hold_cnt, cyc_cnt, c0;
  logic [31:0] rd_val, seen_data, s;
  logic seen_rw, drive_bad;
  int bad_count = 0;
  int comparisons = 0;
  typedef struct packed {logic rd; logic [23:0] a; logic [31:0] d;
    logic [7:0] w;} row_type;
  row_type rows[4] = '{'{1'b1, 24'hFFFFFF, 32'hA5A5_5A5A, 8'h00},
    '{1'b0, 24'h000001, 32'h1234_5678, 8'h00},
    '{1'b1, 24'h800000, 32'h0F0F_F0F0, 8'h09},
    '{1'b0, 24'h7FFFFE, 32'hFFFF_FFFF, 8'h14}};

  // peers drive a flag pin only while the block does not
  assign flag_pin_n_in = (flag_pin_n_oe & flag_pin_n_out) |
    (~flag_pin_n_oe & peer_lvl);

  iofp_top i_iofp_top (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .io_space_strobe_n(io_space_strobe_n),
    .expansion_read_write(expansion_read_write), .io_addr(io_addr),
    .io_data_out(io_data_out), .io_data_oe(io_data_oe),
    .io_data_in(io_data_in), .io_ready_n(io_ready_n),
    .flag_pin_n_in(flag_pin_n_in), .flag_pin_n_out(flag_pin_n_out),
    .flag_pin_n_oe(flag_pin_n_oe));

  iofp_periph_model i_iofp_periph_model (.sys_clk(sys_clk),
    .resetn(resetn), .strobe_n(io_space_strobe_n),
    .rw(expansion_read_write), .addr(io_addr), .dout(io_data_out),
    .oe(io_data_oe), .din(io_data_in), .ready_n(io_ready_n),
    .wait_cyc(wait_cyc), .rd_val(rd_val), .seen_data(seen_data),
    .seen_addr(seen_addr), .seen_rw(seen_rw), .low_cnt(low_cnt),
    .hold_cnt(hold_cnt), .cyc_cnt(cyc_cnt), .drive_bad(drive_bad));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one avalon access; held until waitrequest is seen low
  // a slave that never answers is ended by the watchdog
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
    @(posedge sys_clk);
  endtask

  task automatic cycle(input logic rd, input logic lk,
    input logic [23:0] a, input logic [31:0] d);
    bus(1'b1, iofp_pkg::ADDR_IO_ADDR, {8'h00, a}, s);
    bus(1'b1, iofp_pkg::ADDR_IO_WDATA, d, s);
    bus(1'b1, iofp_pkg::ADDR_IO_CMD, {29'h0, lk, rd, 1'b1}, s);
    do begin
      bus(1'b0, iofp_pkg::ADDR_IO_STAT, 32'h0, s);
    end while (s[0] !== 1'b0);
  endtask

  task automatic settle();
    repeat (3 * iofp_pkg::PHASE_DIV) @(posedge sys_clk);
  endtask

  task automatic flag_chk(input logic [31:0] wv, input logic [1:0] pl,
    input logic [1:0] oe, input logic [1:0] ov, input logic [31:0] m,
    input logic [31:0] rv);
    bus(1'b1, iofp_pkg::ADDR_FLAG_CTRL, wv, s);
    peer_lvl <= pl;
    settle();
    chk(flag_pin_n_oe, oe, "flag oe");
    chk(flag_pin_n_out & oe, ov, "flag out");
    bus(1'b0, iofp_pkg::ADDR_FLAG_CTRL, 32'h0, s);
    chk(s & m, rv, "flag read");
  endtask

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    {resetn, avs_read, avs_write} = 3'b000;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    peer_lvl = 2'b00;
    wait_cyc = 8'h00;
    rd_val = 32'h0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk({avs_waitrequest, io_space_strobe_n, expansion_read_write,
      io_data_oe, flag_pin_n_oe}, 32'h38, "reset outputs");
    bus(1'b0, iofp_pkg::ADDR_FLAG_CTRL, 32'h0, s);
    chk(s & 32'h66, 32'h0, "flag reset");
    $display("test reset done");
    foreach (rows[i]) begin
      c0 = cyc_cnt;
      wait_cyc <= rows[i].w;
      rd_val <= ~rows[i].d;
      cycle(rows[i].rd, 1'b0, rows[i].a, rows[i].d);
      chk(s[1:0], 2'b10, "done");
      chk(cyc_cnt - c0, 8'h01, "one strobe");
      chk(seen_addr, rows[i].a, "addr");
      chk(seen_rw, rows[i].rd, "rw");
      chk(low_cnt > rows[i].w, 1'b1, "extended");
      chk(hold_cnt inside {[2:6]}, !rows[i].rd, "data hold");
      chk(drive_bad, 1'b0, "write drive");
      if (!rows[i].rd)
        chk(seen_data, rows[i].d, "wdata");
      bus(1'b0, iofp_pkg::ADDR_IO_RDATA, 32'h0, s);
      if (rows[i].rd)
        chk(s, ~rows[i].d, "rdata");
      bus(1'b0, iofp_pkg::ADDR_IO_CMD, 32'h0, s);
      chk(s, {8'h00, rows[i].a}, "addr readback");
      bus(1'b0, iofp_pkg::ADDR_IO_STAT, 32'h0, s);
      chk(s[1], 1'b0, "done cleared");
      $display("test row %0d done", i);
    end
    // unmapped place and a command while busy
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, s);
    bus(1'b0, 4'h2, 32'h0, s);
    chk(s, 32'h0, "unmapped");
    c0 = cyc_cnt;
    wait_cyc <= 8'h1E;
    bus(1'b1, iofp_pkg::ADDR_IO_CMD, 32'h1, s);
    cycle(1'b0, 1'b0, 24'h00ABCD, 32'hC0DE_0001);
    chk(cyc_cnt - c0, 8'h01, "busy ignores go");
    $display("test busy done");
    // flag pins: output, sampled input, both directions
    flag_chk(32'h06, 2'b10, 2'b01, 2'b01, 32'hE6, 32'h86);
    flag_chk(32'h06, 2'b00, 2'b01, 2'b01, 32'hE6, 32'h06);
    flag_chk(32'h00, 2'b00, 2'b00, 2'b00, 32'hEE, 32'h00);
    flag_chk(32'h00, 2'b11, 2'b00, 2'b00, 32'hEE, 32'h88);
    flag_chk(32'h60, 2'b01, 2'b10, 2'b10, 32'h6E, 32'h68);
    flag_chk(32'h00, 2'b10, 2'b00, 2'b00, 32'hEE, 32'h80);
    $display("test flags done");
    // locked load: pin zero pulled low, pin one sampled
    wait_cyc <= 8'h14;
    fork
      cycle(1'b1, 1'b1, 24'h000010, 32'h0);
      begin
        wait (io_space_strobe_n === 1'b0);
        repeat (2) @(posedge sys_clk);
        chk(flag_pin_n_oe[0], 1'b1, "lock drive");
        chk(flag_pin_n_out[0], 1'b0, "lock low");
      end
    join
    chk(s[2], 1'b1, "pin one seen");
    $display("test locked load done");
    // mid-run reset must release both pins and clear the control bits
    bus(1'b1, iofp_pkg::ADDR_FLAG_CTRL, 32'h66, s);
    settle();
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(flag_pin_n_oe, 2'b00, "reset oe");
    bus(1'b0, iofp_pkg::ADDR_FLAG_CTRL, 32'h0, s);
    chk(s & 32'h66, 32'h0, "reset ctrl");
    $display("test mid reset done");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
endmodule // tb_io_strobe_and_flag_pins
